/* design/fmx_exec.sv */
// Executor for clear, watchdog restart, file move and bank load
// Behaviour
// RULE1: Clear writes zero to the addressed register, sets only null flag.
// RULE2: Clear access bit 0 forces the fixed bank, 1 uses the bank register.
// RULE3: Watchdog restart clears counter and postscaler, sets expiry, sleep.
// RULE4: Move is two words: 1100 plus source, then 1111 plus destination.
// RULE5: Move reads source, dummy-reads while decoding word two, then writes.
// RULE6: Bank load copies the 8-bit literal into the bank register, no flags.
`timescale 1ns/10ps
`default_nettype none
`include "fmx_params.svh"

module fmx_exec (
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                instr_valid_i,
    input  wire logic [`FMX_IW-1:0]  instr_i,
    output logic                     instr_ready_o,
    output logic [`FMX_AW-1:0]       mem_addr_o,
    output logic                     mem_rd_o,
    output logic                     mem_we_o,
    output logic [`FMX_DW-1:0]       mem_wdata_o,
    input  wire logic [`FMX_DW-1:0]  mem_rdata_i,
    output logic                     watchdog_restart_o,
    output logic                     zero_flag_o,
    output logic                     watchdog_expiry_flag_o,
    output logic                     sleep_entry_flag_o,
    output logic [`FMX_DW-1:0]       bank_select_reg_o,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic [31:0]              prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    function automatic fmx_pkg::fmx_op_type decode_op(
        input logic [`FMX_IW-1:0] w
    );
        fmx_pkg::fmx_op_type op;
        op = fmx_pkg::OP_NONE;
        if (w == `FMX_WD_RESTART_WORD) begin
            op = fmx_pkg::OP_WD_RESTART;
        end else if (w[15:8] == `FMX_BANK_LOAD_PFX) begin
            op = fmx_pkg::OP_BANK_LOAD;
        end else if (w[15:9] == `FMX_CLEAR_PFX) begin
            op = fmx_pkg::OP_CLEAR;
        end else if (w[15:12] == `FMX_MOVE1_PFX) begin
            op = fmx_pkg::OP_MOVE;
        end
        return op;
    endfunction : decode_op

    fmx_pkg::fmx_state_type  state;
    fmx_pkg::fmx_state_type  next_state;
    logic [`FMX_AW-1:0]      next_mem_addr;
    logic                    next_mem_rd;
    logic                    next_mem_we;
    logic [`FMX_DW-1:0]      next_mem_wdata;
    logic [`FMX_DW-1:0]      hold;
    logic [`FMX_DW-1:0]      next_hold;
    logic                    next_watchdog_restart;
    logic                    next_zero;
    logic                    next_expiry;
    logic                    next_sleep;
    logic [`FMX_DW-1:0]      next_bank;
    logic                    ctrl_en;
    logic                    next_ctrl_en;
    logic [31:0]             next_prdata;
    logic                    acc;
    logic                    apb_wr;
    logic                    sts_wr;
    logic                    mapped;

    assign instr_ready_o = ctrl_en && (state != fmx_pkg::ST_MOVE_DUMMY);
    assign acc           = ce_i && instr_valid_i && instr_ready_o;

    // ------------------------------------------------------------------
    // Execution
    // ------------------------------------------------------------------
    always_comb begin
        next_state            = state;
        next_mem_addr         = mem_addr_o;
        next_mem_rd           = 1'b0;
        next_mem_we           = 1'b0;
        next_mem_wdata        = mem_wdata_o;
        next_hold             = hold;
        next_watchdog_restart = 1'b0;
        next_bank             = bank_select_reg_o;
        // Software clear first so that a same-cycle set wins
        next_zero   = zero_flag_o
                      & ~(sts_wr & pwdata_i[`FMX_ST_ZERO_BIT]);
        next_expiry = watchdog_expiry_flag_o
                      & ~(sts_wr & pwdata_i[`FMX_ST_EXPIRY_BIT]);
        next_sleep  = sleep_entry_flag_o
                      & ~(sts_wr & pwdata_i[`FMX_ST_SLEEP_BIT]);
        unique case (state)
            fmx_pkg::ST_IDLE: begin
                if (acc) begin
                    unique case (decode_op(instr_i))
                        fmx_pkg::OP_CLEAR: begin
                            if (instr_i[`FMX_ACCESS_SEL_BIT]) begin
                                next_mem_addr = {bank_select_reg_o[3:0],
                                                 instr_i[7:0]}; // RULE2
                            end else begin
                                next_mem_addr = {`FMX_ACCESS_BANK,
                                                 instr_i[7:0]}; // RULE2
                            end
                            next_mem_we    = 1'b1;              // RULE1
                            next_mem_wdata = `FMX_CLEAR_DATA;   // RULE1
                            next_zero      = 1'b1;              // RULE1
                        end
                        fmx_pkg::OP_WD_RESTART: begin
                            next_watchdog_restart = 1'b1;       // RULE3
                            next_expiry           = 1'b1;       // RULE3
                            next_sleep            = 1'b1;       // RULE3
                        end
                        fmx_pkg::OP_BANK_LOAD: begin
                            next_bank = instr_i[7:0];           // RULE6
                        end
                        fmx_pkg::OP_MOVE: begin
                            next_mem_addr = instr_i[11:0];      // RULE4
                            next_mem_rd   = 1'b1;               // RULE5
                            next_state    = fmx_pkg::ST_MOVE_WAIT;
                        end
                        fmx_pkg::OP_NONE: begin
                        end
                    endcase
                end
            end
            fmx_pkg::ST_MOVE_WAIT: begin
                if (mem_rd_o) begin
                    next_hold = mem_rdata_i;                    // RULE5
                end
                if (acc) begin
                    if (instr_i[15:12] == `FMX_MOVE2_PFX) begin
                        next_mem_addr = instr_i[11:0];          // RULE4
                        next_mem_rd   = 1'b1;                   // RULE5
                        next_state    = fmx_pkg::ST_MOVE_DUMMY;
                    end else begin
                        next_state    = fmx_pkg::ST_IDLE;
                    end
                end
            end
            fmx_pkg::ST_MOVE_DUMMY: begin
                next_mem_we    = 1'b1;                          // RULE5
                next_mem_wdata = hold;                          // RULE5
                next_state     = fmx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state                  <= fmx_pkg::ST_IDLE;
            mem_addr_o             <= '0;
            mem_rd_o               <= 1'b0;
            mem_we_o               <= 1'b0;
            mem_wdata_o            <= '0;
            hold                   <= '0;
            watchdog_restart_o     <= 1'b0;
            zero_flag_o            <= 1'b0;
            watchdog_expiry_flag_o <= 1'b0;
            sleep_entry_flag_o     <= 1'b0;
            bank_select_reg_o      <= `FMX_BANK_RST;
        end else if (ce_i) begin
            state                  <= next_state;
            mem_addr_o             <= next_mem_addr;
            mem_rd_o               <= next_mem_rd;
            mem_we_o               <= next_mem_we;
            mem_wdata_o            <= next_mem_wdata;
            hold                   <= next_hold;
            watchdog_restart_o     <= next_watchdog_restart;
            zero_flag_o            <= next_zero;
            watchdog_expiry_flag_o <= next_expiry;
            sleep_entry_flag_o     <= next_sleep;
            bank_select_reg_o      <= next_bank;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign pready_o  = ce_i;
    assign mapped    = (paddr_i == `FMX_REG_CTRL)
                       || (paddr_i == `FMX_REG_STATUS);
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign apb_wr    = psel_i && penable_i && pwrite_i && ce_i;
    assign sts_wr    = apb_wr && (paddr_i == `FMX_REG_STATUS);

    always_comb begin
        next_ctrl_en = ctrl_en;
        next_prdata  = prdata_o;
        if (apb_wr && (paddr_i == `FMX_REG_CTRL)) begin
            next_ctrl_en = pwdata_i[`FMX_CTRL_EN_BIT];
        end
        if (psel_i && !penable_i) begin
            next_prdata = '0;
            if (paddr_i == `FMX_REG_CTRL) begin
                next_prdata[`FMX_CTRL_EN_BIT] = ctrl_en;
            end else if (paddr_i == `FMX_REG_STATUS) begin
                next_prdata[`FMX_ST_ZERO_BIT]   = zero_flag_o;
                next_prdata[`FMX_ST_EXPIRY_BIT] = watchdog_expiry_flag_o;
                next_prdata[`FMX_ST_SLEEP_BIT]  = sleep_entry_flag_o;
                next_prdata[`FMX_ST_BANK_LSB +: `FMX_DW] = bank_select_reg_o;
                next_prdata[`FMX_ST_BUSY_BIT] =
                    (state != fmx_pkg::ST_IDLE);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_en  <= `FMX_CTRL_EN_RST;
            prdata_o <= '0;
        end else if (ce_i) begin
            ctrl_en  <= next_ctrl_en;
            prdata_o <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    property p_clear_writes_zero;
        acc && state == fmx_pkg::ST_IDLE && !sts_wr
            && decode_op(instr_i) == fmx_pkg::OP_CLEAR
        |=> mem_we_o && mem_wdata_o == `FMX_CLEAR_DATA && zero_flag_o
            && $stable(watchdog_expiry_flag_o)
            && $stable(sleep_entry_flag_o);
    endproperty
    a_clear_writes_zero: assert property (p_clear_writes_zero) // RULE1
        else $error("clear did not write zero and set null flag");

    property p_clear_fixed_bank;
        acc && state == fmx_pkg::ST_IDLE && !instr_i[`FMX_ACCESS_SEL_BIT]
            && decode_op(instr_i) == fmx_pkg::OP_CLEAR
        |=> mem_addr_o[11:8] == `FMX_ACCESS_BANK;
    endproperty
    a_clear_fixed_bank: assert property (p_clear_fixed_bank) // RULE2
        else $error("clear with access bit 0 missed fixed bank");

    property p_clear_bank_reg;
        acc && state == fmx_pkg::ST_IDLE && instr_i[`FMX_ACCESS_SEL_BIT]
            && decode_op(instr_i) == fmx_pkg::OP_CLEAR
        |=> mem_addr_o[11:8] == bank_select_reg_o[3:0];
    endproperty
    a_clear_bank_reg: assert property (p_clear_bank_reg) // RULE2
        else $error("clear with access bit 1 ignored bank register");

    property p_wd_restart;
        acc && state == fmx_pkg::ST_IDLE && instr_i == `FMX_WD_RESTART_WORD
        |=> watchdog_restart_o && watchdog_expiry_flag_o
            && sleep_entry_flag_o;
    endproperty
    a_wd_restart: assert property (p_wd_restart) // RULE3
        else $error("watchdog restart effects missing");

    property p_move_source;
        acc && state == fmx_pkg::ST_IDLE
            && decode_op(instr_i) == fmx_pkg::OP_MOVE
        |=> mem_rd_o && mem_addr_o == $past(instr_i[11:0])
            && state == fmx_pkg::ST_MOVE_WAIT;
    endproperty
    a_move_source: assert property (p_move_source) // RULE4
        else $error("move first word did not read source");

    property p_move_write;
        acc && state == fmx_pkg::ST_MOVE_WAIT
            && instr_i[15:12] == `FMX_MOVE2_PFX ##1 ce_i
        |=> mem_we_o && !mem_rd_o && mem_addr_o == $past(mem_addr_o)
            && mem_wdata_o == $past(hold);
    endproperty
    a_move_write: assert property (p_move_write) // RULE5
        else $error("move did not write held data to destination");

    property p_bank_load;
        acc && state == fmx_pkg::ST_IDLE && !sts_wr
            && decode_op(instr_i) == fmx_pkg::OP_BANK_LOAD
        |=> bank_select_reg_o == $past(instr_i[7:0]) && $stable(zero_flag_o)
            && $stable(sleep_entry_flag_o);
    endproperty
    a_bank_load: assert property (p_bank_load) // RULE6
        else $error("bank load wrong or altered a flag");

    c_clear: cover property (mem_we_o && !$past(mem_we_o));
    c_restart: cover property (watchdog_restart_o);
    c_move: cover property (state == fmx_pkg::ST_MOVE_DUMMY ##1 mem_we_o);
    c_bank: cover property ($changed(bank_select_reg_o));

endmodule : fmx_exec
`default_nettype wire

/* design/fmx_params.svh */
// Constants for the file-move instruction executor
`ifndef FMX_PARAMS_SVH
`define FMX_PARAMS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define FMX_IW              16
`define FMX_AW              12
`define FMX_DW              8

// ----------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------
`define FMX_WD_RESTART_WORD 16'h0004
`define FMX_BANK_LOAD_PFX   8'h01
`define FMX_CLEAR_PFX       7'h2a
`define FMX_MOVE1_PFX       4'hc
`define FMX_MOVE2_PFX       4'hf
`define FMX_ACCESS_SEL_BIT  8
`define FMX_ACCESS_BANK     4'h0
`define FMX_CLEAR_DATA      8'h00

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define FMX_REG_CTRL        12'h000
`define FMX_REG_STATUS      12'h004
`define FMX_CTRL_EN_BIT     0
`define FMX_CTRL_EN_RST     1'b1
`define FMX_ST_ZERO_BIT     0
`define FMX_ST_EXPIRY_BIT   1
`define FMX_ST_SLEEP_BIT    2
`define FMX_ST_BANK_LSB     8
`define FMX_ST_BUSY_BIT     16
`define FMX_BANK_RST        8'h00

`endif

/* design/fmx_pkg.sv */
// Types for the file-move instruction executor
`default_nettype none
package fmx_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_CLEAR,
        OP_WD_RESTART,
        OP_MOVE,
        OP_BANK_LOAD
    } fmx_op_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MOVE_WAIT,
        ST_MOVE_DUMMY
    } fmx_state_type;

endpackage : fmx_pkg
`default_nettype wire

/* dv/fmx_mem_model.sv */
// Behavioural banked data memory facing the executor
`timescale 1ns/10ps
`default_nettype none
`include "fmx_params.svh"

module fmx_mem_model (
    input  wire logic               core_clk_i,
    input  wire logic               ce_i,
    input  wire logic [`FMX_AW-1:0] mem_addr_i,
    input  wire logic               mem_rd_i,
    input  wire logic               mem_we_i,
    input  wire logic [`FMX_DW-1:0] mem_wdata_i,
    output logic      [`FMX_DW-1:0] mem_rdata_o
);
    logic [`FMX_DW-1:0] mem [0:(1<<`FMX_AW)-1];
    logic [`FMX_DW-1:0] last;

    // ------------------------------------------------------------------
    // Storage, preloaded with a known pattern
    // ------------------------------------------------------------------
    initial begin
        last = 8'h00;
        for (int i = 0; i < (1<<`FMX_AW); i++) begin
            mem[i] = i[7:0] ^ 8'ha5;
        end
    end

    always @(posedge core_clk_i) begin
        if (ce_i && mem_we_i) begin
            mem[mem_addr_i] <= mem_wdata_i;
        end
        if (ce_i && mem_rd_i) begin
            last <= mem[mem_addr_i];
        end
    end

    // Same-cycle read; inverted stale data when not reading
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last;
endmodule : fmx_mem_model
`default_nettype wire

/* dv/test_file_move_instruction_exec.sv */
// Self-checking bench for the file-move instruction executor
`timescale 1ns/10ps
`default_nettype none
`include "fmx_params.svh"

module test_file_move_instruction_exec;
    logic        core_clk_i, rst_i, ce_i, instr_valid_i, instr_ready_o;
    logic [15:0] instr_i;
    logic [11:0] mem_addr_o, paddr_i;
    logic        mem_rd_o, mem_we_o, watchdog_restart_o, zero_flag_o;
    logic [7:0]  mem_wdata_o, mem_rdata_i, bank_select_reg_o;
    logic        watchdog_expiry_flag_o, sleep_entry_flag_o;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
    logic [31:0] pwdata_i, prdata_o, rd;
    int          miscompares, n_tests;

    fmx_exec fmx_exec_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .instr_ready_o(instr_ready_o), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_we_o(mem_we_o),
        .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .watchdog_restart_o(watchdog_restart_o), .zero_flag_o(zero_flag_o),
        .watchdog_expiry_flag_o(watchdog_expiry_flag_o),
        .sleep_entry_flag_o(sleep_entry_flag_o),
        .bank_select_reg_o(bank_select_reg_o), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o));

    fmx_mem_model fmx_mem_model_i (.core_clk_i(core_clk_i), .ce_i(ce_i),
        .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_we_i(mem_we_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

    // ------------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------------
    initial core_clk_i = 1'b0;
    always #2 core_clk_i = ~core_clk_i;

    task summarize;
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task send(input logic [15:0] w, input logic keep);
        int k;
        instr_valid_i <= 1'b1;
        instr_i       <= w;
        k = 0;
        do begin
            @(negedge core_clk_i);
            k++;
        end while (instr_ready_o !== 1'b1 && k < 20);
        @(posedge core_clk_i);
        if (!keep) instr_valid_i <= 1'b0;
        if (k >= 20) begin
            miscompares++;
            summarize;
        end
    endtask : send

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= wd;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            miscompares++;
            summarize;
        end
        @(posedge core_clk_i);
    endtask : apb

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        @(negedge core_clk_i);
        chk({zero_flag_o, watchdog_expiry_flag_o, sleep_entry_flag_o,
             bank_select_reg_o, instr_ready_o}, {3'b000, 8'h00, 1'b1});
        @(posedge core_clk_i);
        apb(1'b0, `FMX_REG_CTRL, 32'h0);
        chk({err, rd}, {1'b0, 32'h1});
    endtask : t_reset

    task t_restart;
        send(`FMX_WD_RESTART_WORD, 1'b0);
        ce_i <= 1'b0;
        @(negedge core_clk_i);
        chk({watchdog_restart_o, watchdog_expiry_flag_o, sleep_entry_flag_o,
             zero_flag_o}, 4'b1110);
        repeat (2) @(negedge core_clk_i);
        chk(watchdog_restart_o, 1'b1);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        repeat (2) @(negedge core_clk_i);
        chk(watchdog_restart_o, 1'b0);
        @(posedge core_clk_i);
    endtask : t_restart

    task t_bank;
        send({`FMX_BANK_LOAD_PFX, 8'h35}, 1'b0);
        @(negedge core_clk_i);
        chk({bank_select_reg_o, watchdog_expiry_flag_o, sleep_entry_flag_o,
             zero_flag_o}, {8'h35, 3'b110});
        @(posedge core_clk_i);
        apb(1'b1, `FMX_REG_STATUS, 32'h7);
        apb(1'b0, `FMX_REG_STATUS, 32'h0);
        chk(rd, 32'h3500);
    endtask : t_bank

    task t_clear(input logic a, input logic [7:0] f);
        logic [11:0] ea;
        ea = a ? {4'h5, f} : {`FMX_ACCESS_BANK, f};
        apb(1'b1, `FMX_REG_STATUS, 32'h7);
        send({`FMX_CLEAR_PFX, a, f}, 1'b0);
        @(negedge core_clk_i);
        chk({mem_we_o, mem_addr_o, mem_wdata_o}, {1'b1, ea, 8'h00});
        chk({zero_flag_o, watchdog_expiry_flag_o, sleep_entry_flag_o},
            3'b100);
        @(negedge core_clk_i);
        chk(fmx_mem_model_i.mem[ea], 8'h00);
        @(posedge core_clk_i);
    endtask : t_clear

    task t_move(input int gap);
        logic [11:0] dst;
        dst = 12'h456 + 12'(gap);
        send({`FMX_MOVE1_PFX, 12'h123}, gap == 0);
        if (gap == 0) instr_i <= {`FMX_MOVE2_PFX, dst};
        @(negedge core_clk_i);
        chk({mem_rd_o, mem_addr_o}, {1'b1, 12'h123});
        if (gap == 0) begin
            @(posedge core_clk_i);
            instr_valid_i <= 1'b0;
        end else begin
            repeat (gap) @(posedge core_clk_i);
            send({`FMX_MOVE2_PFX, dst}, 1'b0);
        end
        @(negedge core_clk_i);
        chk({mem_rd_o, mem_addr_o, instr_ready_o}, {1'b1, dst, 1'b0});
        @(negedge core_clk_i);
        chk({mem_we_o, mem_addr_o, mem_wdata_o, instr_ready_o, zero_flag_o},
            {1'b1, dst, 8'h86, 1'b1, 1'b1});
        @(posedge core_clk_i);
    endtask : t_move

    task t_apb;
        apb(1'b0, 12'h008, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b1, `FMX_REG_CTRL, 32'h0);
        instr_valid_i <= 1'b1;
        instr_i       <= {`FMX_BANK_LOAD_PFX, 8'h77};
        repeat (3) @(posedge core_clk_i);
        instr_valid_i <= 1'b0;
        @(negedge core_clk_i);
        chk({instr_ready_o, bank_select_reg_o}, {1'b0, 8'h35});
        @(posedge core_clk_i);
        apb(1'b1, `FMX_REG_CTRL, 32'h1);
    endtask : t_apb

    initial begin
        miscompares   = 0;
        n_tests       = 0;
        rst_i         = 1'b1;
        ce_i          = 1'b1;
        instr_valid_i = 1'b0;
        instr_i       = 16'h0000;
        psel_i        = 1'b0;
        penable_i     = 1'b0;
        pwrite_i      = 1'b0;
        paddr_i       = 12'h000;
        pwdata_i      = 32'h0000_0000;
        repeat (16) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset;
        t_restart;
        t_bank;
        t_clear(1'b1, 8'h42);
        t_clear(1'b0, 8'h13);
        t_move(0);
        t_move(3);
        t_apb;
        summarize;
    end
endmodule : test_file_move_instruction_exec
`default_nettype wire
